// ---- common/derf_pkg.sv ----
/*
 Constants and types for the dual element data register file.
 Assumes one core clock and that every user of these names writes the
 package prefix in full; nothing here holds logic.
*/
package derf_pkg;
   localparam int DATA_W   = 40;
   localparam int WORD_W   = 32;
   localparam int LOW_W    = DATA_W - WORD_W;
   localparam int NUM_REGS = 16;
   localparam int IDX_W    = 4;
   localparam int NUM_ELEM = 2;
   localparam int NUM_SETS = 2;
   localparam int BUS_W    = 64;
   localparam int PX_W     = 64;
   localparam int PX_CUT_W = PX_W - DATA_W;
   localparam int PX_HI_LSB = 32;
   localparam int MR_W     = 80;
   localparam int ADDR_W   = 24;
   localparam int SET_LATENCY = 1;
   localparam logic [DATA_W-1:0] DATA_RST = 40'h0;
   localparam logic [PX_W-1:0]   PX_RST   = 64'h0;
   localparam logic [MR_W-1:0]   MR_RST   = 80'h0;
   // Write ports, lowest index has the highest precedence
   localparam int WR_UREG     = 0;
   localparam int WR_DM_EVEN  = 1;
   localparam int WR_DM_ODD   = 2;
   localparam int WR_PM_EVEN  = 3;
   localparam int WR_PM_ODD   = 4;
   localparam int WR_ALU      = 5;
   localparam int WR_MULT     = 6;
   localparam int WR_SHIFT    = 7;
   localparam int NUM_WR      = 8;
   // Read ports
   localparam int RD_OP_A     = 0;
   localparam int RD_OP_B     = 1;
   localparam int RD_DM_EVEN  = 2;
   localparam int RD_DM_ODD   = 3;
   localparam int RD_PM_EVEN  = 4;
   localparam int RD_PM_ODD   = 5;
   localparam int RD_UREG     = 6;
   localparam int NUM_RD      = 7;
   typedef enum logic [1:0] {
      XF_32 = 2'b00,
      XF_40 = 2'b01,
      XF_LW = 2'b10
   } derf_xfer_t;
   typedef enum logic [2:0] {
      UR_FIRST  = 3'b000,
      UR_SECOND = 3'b001,
      UR_PX_LOW = 3'b010,
      UR_PX_HI  = 3'b011,
      UR_PX     = 3'b100,
      UR_PC     = 3'b101,
      UR_FETCH  = 3'b110,
      UR_DECODE = 3'b111
   } derf_ureg_t;
endpackage

// ---- core/derf_bank.sv ----
/*
 One element's data register file: primary and alternate sets of forty
 bit registers, prioritised write ports and combinational read ports.
 Assumes the set select is already delayed by the caller.
*/
`timescale 1ns/10ps
module derf_bank (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 set_sel_i,
   input  wire logic [derf_pkg::NUM_WR-1:0] wr_en_i,
   input  wire logic [derf_pkg::NUM_WR-1:0][derf_pkg::IDX_W-1:0] wr_idx_i,
   input  wire logic [derf_pkg::NUM_WR-1:0][derf_pkg::DATA_W-1:0] wr_data_i,
   input  wire logic [derf_pkg::NUM_RD-1:0][derf_pkg::IDX_W-1:0] rd_idx_i,
   output logic [derf_pkg::NUM_RD-1:0][derf_pkg::DATA_W-1:0] rd_data_o
);
   logic [derf_pkg::DATA_W-1:0] mem_reg [derf_pkg::NUM_SETS*derf_pkg::NUM_REGS];

   // One flop group per entry; only the selected set may change
   for (genvar g = 0; g < derf_pkg::NUM_SETS*derf_pkg::NUM_REGS; g++) begin : g_ent
      localparam logic                      SET = 1'(g / derf_pkg::NUM_REGS);
      localparam logic [derf_pkg::IDX_W-1:0] IDX = 4'(g % derf_pkg::NUM_REGS);
      logic                        hit;
      logic [derf_pkg::DATA_W-1:0] mem_next;
      // Walk from lowest precedence up so the strongest source lands last
      always_comb begin
         hit      = 1'b0;
         mem_next = mem_reg[g];
         for (int k = derf_pkg::NUM_WR-1; k >= 0; k--) begin
            if (wr_en_i[k] && wr_idx_i[k] == IDX) begin
               hit      = 1'b1;
               mem_next = wr_data_i[k];
            end
         end
         if (set_sel_i != SET) begin
            hit      = 1'b0;
            mem_next = mem_reg[g];
         end
      end
      always_ff @(posedge clk_i or posedge rst_i) begin
         if (rst_i) begin
            mem_reg[g] <= derf_pkg::DATA_RST;
         end else if (hit) begin
            mem_reg[g] <= mem_next;
         end
      end
      inactive_hold_a: assert property (
         @(posedge clk_i) disable iff (rst_i)
         (set_sel_i != SET) |=> mem_reg[g] == $past(mem_reg[g]))
         else $error("unselected register changed");
      top_prio_a: assert property (
         @(posedge clk_i) disable iff (rst_i)
         (set_sel_i == SET && wr_en_i[0] && wr_idx_i[0] == IDX)
         |=> mem_reg[g] == $past(wr_data_i[0]))
         else $error("highest precedence write lost");
   end

   // Every read port sees the selected set, so no port waits on another
   for (genvar p = 0; p < derf_pkg::NUM_RD; p++) begin : g_rd
      assign rd_data_o[p] = mem_reg[{set_sel_i, rd_idx_i[p]}];
   end
endmodule

// ---- core/derf_top.sv ----
/*
 Dual element data register file: two banks, bus formatting for the
 program and data memory data buses, universal moves, the bus exchange
 register and the multiplier result sets.
 Assumes the sequencer presents decoded controls in the cycle they act,
 and the computational units return results with their destinations.
*/
`timescale 1ns/10ps
module derf_top #(
   parameter int ADDR_W = derf_pkg::ADDR_W
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 alt_set_i,
   input  wire logic                 multi_data_mode_i,
   input  wire logic [derf_pkg::IDX_W-1:0] op_a_idx_i,
   input  wire logic [derf_pkg::IDX_W-1:0] op_b_idx_i,
   output logic [derf_pkg::NUM_ELEM-1:0][derf_pkg::DATA_W-1:0] op_a_o,
   output logic [derf_pkg::NUM_ELEM-1:0][derf_pkg::DATA_W-1:0] op_b_o,
   input  wire logic                 alu_wr_i,
   input  wire logic [derf_pkg::IDX_W-1:0] alu_idx_i,
   input  wire logic [derf_pkg::NUM_ELEM-1:0][derf_pkg::DATA_W-1:0] alu_res_i,
   input  wire logic                 mult_wr_i,
   input  wire logic [derf_pkg::IDX_W-1:0] mult_idx_i,
   input  wire logic [derf_pkg::NUM_ELEM-1:0][derf_pkg::DATA_W-1:0] mult_res_i,
   input  wire logic                 shift_wr_i,
   input  wire logic [derf_pkg::IDX_W-1:0] shift_idx_i,
   input  wire logic [derf_pkg::NUM_ELEM-1:0][derf_pkg::DATA_W-1:0] shift_res_i,
   input  wire logic                 dm_en_i,
   input  wire logic                 dm_wr_i,
   input  wire logic                 dm_second_i,
   input  derf_pkg::derf_xfer_t      dm_xfer_i,
   input  wire logic [derf_pkg::IDX_W-1:0] dm_idx_i,
   input  wire logic [derf_pkg::NUM_ELEM-1:0][derf_pkg::BUS_W-1:0] dm_wdata_i,
   output logic [derf_pkg::NUM_ELEM-1:0][derf_pkg::BUS_W-1:0] dm_rdata_o,
   input  wire logic                 pm_en_i,
   input  wire logic                 pm_wr_i,
   input  wire logic                 pm_second_i,
   input  derf_pkg::derf_xfer_t      pm_xfer_i,
   input  wire logic [derf_pkg::IDX_W-1:0] pm_idx_i,
   input  wire logic [derf_pkg::NUM_ELEM-1:0][derf_pkg::BUS_W-1:0] pm_wdata_i,
   output logic [derf_pkg::NUM_ELEM-1:0][derf_pkg::BUS_W-1:0] pm_rdata_o,
   input  wire logic                 px_ld_dm_i,
   input  wire logic                 px_ld_pm_i,
   output logic [derf_pkg::PX_W-1:0] px_o,
   input  wire logic                 ur_en_i,
   input  derf_pkg::derf_ureg_t      ur_src_i,
   input  wire logic [derf_pkg::IDX_W-1:0] ur_src_idx_i,
   input  derf_pkg::derf_ureg_t      ur_dst_i,
   input  wire logic [derf_pkg::IDX_W-1:0] ur_dst_idx_i,
   input  wire logic [ADDR_W-1:0]    pc_i,
   input  wire logic [ADDR_W-1:0]    fetch_addr_i,
   input  wire logic [ADDR_W-1:0]    decode_addr_i,
   output logic                      ur_refused_o,
   input  wire logic                 mr_wr_i,
   input  wire logic                 mr_swap_i,
   input  wire logic [derf_pkg::NUM_ELEM-1:0][derf_pkg::MR_W-1:0] mr_res_i,
   output logic [derf_pkg::NUM_ELEM-1:0][derf_pkg::MR_W-1:0] mr_fore_o
);
   localparam int DW = derf_pkg::DATA_W;
   localparam int WW = derf_pkg::WORD_W;
   localparam int NE = derf_pkg::NUM_ELEM;
   localparam int NW = derf_pkg::NUM_WR;
   localparam int NR = derf_pkg::NUM_RD;
   localparam int IW = derf_pkg::IDX_W;
   localparam int BW = derf_pkg::BUS_W;
   localparam logic [derf_pkg::LOW_W-1:0]    LOW_ZERO = 8'h0;
   localparam logic [derf_pkg::PX_CUT_W-1:0] CUT_ZERO = 24'h0;
   localparam logic [WW-1:0]                 WORD_ZERO = 32'h0;

   // Inbound 32-bit words land in the top of the register
   function automatic logic [DW-1:0] word_in(input logic [WW-1:0] w);
      word_in = {w, LOW_ZERO};
   endfunction

   // Even register image of an incoming bus word
   function automatic logic [DW-1:0] bus_even(input logic [BW-1:0] b,
                                              input derf_pkg::derf_xfer_t x);
      bus_even = (x == derf_pkg::XF_40) ? b[BW-1 -: DW] : word_in(b[WW-1:0]);
   endfunction

   // Outbound bus word; the low byte never reaches the bus on 32-bit use
   function automatic logic [BW-1:0] bus_out(input logic [DW-1:0] ev,
                                             input logic [DW-1:0] od,
                                             input derf_pkg::derf_xfer_t x);
      unique case (x)
         derf_pkg::XF_40: bus_out = {ev, CUT_ZERO};
         derf_pkg::XF_LW: bus_out = {od[DW-1 -: WW], ev[DW-1 -: WW]};
         default:         bus_out = {WORD_ZERO, ev[DW-1 -: WW]};
      endcase
   endfunction

   logic                   set_sel_reg;
   logic [derf_pkg::PX_W-1:0] px_reg;
   logic [derf_pkg::PX_W-1:0] px_next;
   logic                   refused_reg;
   logic [NE-1:0][NW-1:0]  wr_en;
   logic [NE-1:0][NW-1:0][IW-1:0] wr_idx;
   logic [NE-1:0][NW-1:0][DW-1:0] wr_data;
   logic [NE-1:0][NR-1:0][IW-1:0] rd_idx;
   logic [NE-1:0][NR-1:0][DW-1:0] rd_data;
   logic [NE-1:0][BW-1:0]  dm_rd_reg;
   logic [NE-1:0][BW-1:0]  pm_rd_reg;
   logic [NE-1:0][derf_pkg::MR_W-1:0] mr_fore_reg;
   logic [NE-1:0][derf_pkg::MR_W-1:0] mr_back_reg;

   // Set switch takes effect one cycle after the mode bit changes
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         set_sel_reg <= 1'b0;
      end else begin
         set_sel_reg <= alt_set_i;
      end
   end

   // Universal move decode; sequencer addresses only feed the source side
   wire ro_dst  = ur_dst_i == derf_pkg::UR_PC ||
                  ur_dst_i == derf_pkg::UR_FETCH ||
                  ur_dst_i == derf_pkg::UR_DECODE;
   wire ur_ok   = ur_en_i && !ro_dst;
   wire [WW-1:0] pc_w     = WW'(pc_i);
   wire [WW-1:0] fetch_w  = WW'(fetch_addr_i);
   wire [WW-1:0] decode_w = WW'(decode_addr_i);
   logic [DW-1:0] ur_val;
   always_comb begin
      unique case (ur_src_i)
         derf_pkg::UR_FIRST:  ur_val = rd_data[0][derf_pkg::RD_UREG];
         derf_pkg::UR_SECOND: ur_val = rd_data[1][derf_pkg::RD_UREG];
         derf_pkg::UR_PX_LOW: ur_val = word_in(px_reg[WW-1:0]);
         derf_pkg::UR_PX_HI:  ur_val = word_in(px_reg[derf_pkg::PX_HI_LSB +: WW]);
         derf_pkg::UR_PX:     ur_val = px_reg[derf_pkg::PX_W-1 -: DW];
         derf_pkg::UR_PC:     ur_val = word_in(pc_w);
         derf_pkg::UR_FETCH:  ur_val = word_in(fetch_w);
         derf_pkg::UR_DECODE: ur_val = word_in(decode_w);
      endcase
   end

   // Exchange register: move writes beat bus loads; halves stay separate
   always_comb begin
      px_next = px_reg;
      if (px_ld_pm_i) begin
         px_next = pm_wdata_i[0];
      end
      if (px_ld_dm_i) begin
         px_next = dm_wdata_i[0];
      end
      if (ur_ok && ur_dst_i == derf_pkg::UR_PX_LOW) begin
         px_next[WW-1:0] = ur_val[DW-1 -: WW];
      end
      if (ur_ok && ur_dst_i == derf_pkg::UR_PX_HI) begin
         px_next[derf_pkg::PX_HI_LSB +: WW] = ur_val[DW-1 -: WW];
      end
      if (ur_ok && ur_dst_i == derf_pkg::UR_PX) begin
         px_next = {ur_val, CUT_ZERO};
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         px_reg      <= derf_pkg::PX_RST;
         refused_reg <= 1'b0;
      end else begin
         px_reg      <= px_next;
         refused_reg <= ur_en_i && ro_dst;
      end
   end
   assign px_o         = px_reg;
   assign ur_refused_o = refused_reg;

   // Per element wiring: one index set drives both banks
   for (genvar e = 0; e < NE; e++) begin : g_el
      wire dm_on  = dm_en_i && (e == 0 || dm_second_i);
      wire pm_on  = pm_en_i && (e == 0 || pm_second_i);
      wire cmp_on = e == 0 || multi_data_mode_i;
      wire dm_lw  = dm_xfer_i == derf_pkg::XF_LW;
      wire pm_lw  = pm_xfer_i == derf_pkg::XF_LW;
      wire [IW-1:0] dm_ev = dm_lw ? {dm_idx_i[IW-1:1], 1'b0} : dm_idx_i;
      wire [IW-1:0] pm_ev = pm_lw ? {pm_idx_i[IW-1:1], 1'b0} : pm_idx_i;
      wire [IW-1:0] dm_od = {dm_idx_i[IW-1:1], 1'b1};
      wire [IW-1:0] pm_od = {pm_idx_i[IW-1:1], 1'b1};
      wire ur_here = ur_ok && ur_dst_i == ((e == 0) ? derf_pkg::UR_FIRST
                                                    : derf_pkg::UR_SECOND);

      // Write ports, listed in precedence order
      assign wr_en[e][derf_pkg::WR_UREG]    = ur_here;
      assign wr_idx[e][derf_pkg::WR_UREG]   = ur_dst_idx_i;
      assign wr_data[e][derf_pkg::WR_UREG]  = ur_val;
      assign wr_en[e][derf_pkg::WR_DM_EVEN] = dm_on && dm_wr_i;
      assign wr_idx[e][derf_pkg::WR_DM_EVEN] = dm_ev;
      assign wr_data[e][derf_pkg::WR_DM_EVEN] = bus_even(dm_wdata_i[e], dm_xfer_i);
      assign wr_en[e][derf_pkg::WR_DM_ODD]  = dm_on && dm_wr_i && dm_lw;
      assign wr_idx[e][derf_pkg::WR_DM_ODD] = dm_od;
      assign wr_data[e][derf_pkg::WR_DM_ODD] = word_in(dm_wdata_i[e][BW-1 -: WW]);
      assign wr_en[e][derf_pkg::WR_PM_EVEN] = pm_on && pm_wr_i;
      assign wr_idx[e][derf_pkg::WR_PM_EVEN] = pm_ev;
      assign wr_data[e][derf_pkg::WR_PM_EVEN] = bus_even(pm_wdata_i[e], pm_xfer_i);
      assign wr_en[e][derf_pkg::WR_PM_ODD]  = pm_on && pm_wr_i && pm_lw;
      assign wr_idx[e][derf_pkg::WR_PM_ODD] = pm_od;
      assign wr_data[e][derf_pkg::WR_PM_ODD] = word_in(pm_wdata_i[e][BW-1 -: WW]);
      assign wr_en[e][derf_pkg::WR_ALU]     = alu_wr_i && cmp_on;
      assign wr_idx[e][derf_pkg::WR_ALU]    = alu_idx_i;
      assign wr_data[e][derf_pkg::WR_ALU]   = alu_res_i[e];
      assign wr_en[e][derf_pkg::WR_MULT]    = mult_wr_i && cmp_on;
      assign wr_idx[e][derf_pkg::WR_MULT]   = mult_idx_i;
      assign wr_data[e][derf_pkg::WR_MULT]  = mult_res_i[e];
      assign wr_en[e][derf_pkg::WR_SHIFT]   = shift_wr_i && cmp_on;
      assign wr_idx[e][derf_pkg::WR_SHIFT]  = shift_idx_i;
      assign wr_data[e][derf_pkg::WR_SHIFT] = shift_res_i[e];

      // Read ports; operand indices are shared between elements
      assign rd_idx[e][derf_pkg::RD_OP_A]    = op_a_idx_i;
      assign rd_idx[e][derf_pkg::RD_OP_B]    = op_b_idx_i;
      assign rd_idx[e][derf_pkg::RD_DM_EVEN] = dm_ev;
      assign rd_idx[e][derf_pkg::RD_DM_ODD]  = dm_od;
      assign rd_idx[e][derf_pkg::RD_PM_EVEN] = pm_ev;
      assign rd_idx[e][derf_pkg::RD_PM_ODD]  = pm_od;
      assign rd_idx[e][derf_pkg::RD_UREG]    = ur_src_idx_i;
      assign op_a_o[e] = rd_data[e][derf_pkg::RD_OP_A];
      assign op_b_o[e] = rd_data[e][derf_pkg::RD_OP_B];

      derf_bank u_bank (
         .clk_i     (clk_i),
         .rst_i     (rst_i),
         .set_sel_i (set_sel_reg),
         .wr_en_i   (wr_en[e]),
         .wr_idx_i  (wr_idx[e]),
         .wr_data_i (wr_data[e]),
         .rd_idx_i  (rd_idx[e]),
         .rd_data_o (rd_data[e])
      );

      // Bus read words are registered; a word is up to 64 bits wide
      always_ff @(posedge clk_i or posedge rst_i) begin
         if (rst_i) begin
            dm_rd_reg[e] <= 64'h0;
            pm_rd_reg[e] <= 64'h0;
         end else begin
            if (dm_on && !dm_wr_i) begin
               dm_rd_reg[e] <= bus_out(rd_data[e][derf_pkg::RD_DM_EVEN],
                  rd_data[e][derf_pkg::RD_DM_ODD], dm_xfer_i);
            end
            if (pm_on && !pm_wr_i) begin
               pm_rd_reg[e] <= bus_out(rd_data[e][derf_pkg::RD_PM_EVEN],
                  rd_data[e][derf_pkg::RD_PM_ODD], pm_xfer_i);
            end
         end
      end
      assign dm_rdata_o[e] = dm_rd_reg[e];
      assign pm_rdata_o[e] = pm_rd_reg[e];

      // Result sets live outside the move map; swap beats a new result
      always_ff @(posedge clk_i or posedge rst_i) begin
         if (rst_i) begin
            mr_fore_reg[e] <= derf_pkg::MR_RST;
            mr_back_reg[e] <= derf_pkg::MR_RST;
         end else if (mr_swap_i) begin
            mr_fore_reg[e] <= mr_back_reg[e];
            mr_back_reg[e] <= mr_fore_reg[e];
         end else if (mr_wr_i && cmp_on) begin
            mr_fore_reg[e] <= mr_res_i[e];
         end
      end
      assign mr_fore_o[e] = mr_fore_reg[e];

      gate_second_a: assert property (
         @(posedge clk_i) disable iff (rst_i)
         (e == 1 && !multi_data_mode_i) |->
         !(wr_en[e][derf_pkg::WR_ALU] || wr_en[e][derf_pkg::WR_MULT] ||
           wr_en[e][derf_pkg::WR_SHIFT]))
         else $error("second element computed in single data mode");
      mr_swap_a: assert property (
         @(posedge clk_i) disable iff (rst_i)
         mr_swap_i |=> mr_fore_reg[e] == $past(mr_back_reg[e]) &&
                       mr_back_reg[e] == $past(mr_fore_reg[e]))
         else $error("result set swap wrong");
   end

   sequence s_set_flip;
      $changed(alt_set_i) ##0 (set_sel_reg != alt_set_i);
   endsequence
   sequence s_set_done;
      ##1 (set_sel_reg == $past(alt_set_i));
   endsequence
   set_latency_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_set_flip |-> s_set_done)
      else $error("register set switch latency wrong");
   ro_refuse_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (ur_en_i && ro_dst && !px_ld_dm_i && !px_ld_pm_i)
      |=> ur_refused_o && px_reg == $past(px_reg))
      else $error("write to read-only address register acted");
   px_half_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (ur_en_i && ur_dst_i == derf_pkg::UR_PX_LOW && !px_ld_dm_i &&
       !px_ld_pm_i) |=> px_reg[derf_pkg::PX_HI_LSB +: WW] ==
                        $past(px_reg[derf_pkg::PX_HI_LSB +: WW]))
      else $error("low half write disturbed high half");
   // Self move of the combined register shows the 40-bit image plainly
   px_move_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (ur_en_i && ur_src_i == derf_pkg::UR_PX &&
       ur_dst_i == derf_pkg::UR_PX) |=>
      px_reg == {$past(px_reg[derf_pkg::PX_W-1 -: DW]), CUT_ZERO})
      else $error("combined exchange move not upper forty bits");
   lw_pair_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (dm_en_i && dm_wr_i && dm_xfer_i == derf_pkg::XF_LW) |->
      wr_en[0][derf_pkg::WR_DM_ODD] && !wr_idx[0][derf_pkg::WR_DM_EVEN][0] &&
      wr_idx[0][derf_pkg::WR_DM_ODD] ==
      (wr_idx[0][derf_pkg::WR_DM_EVEN] | 4'h1))
      else $error("long word pair misformed");
   word_read_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (dm_en_i && !dm_wr_i && dm_xfer_i == derf_pkg::XF_32) |=>
      dm_rdata_o[0] == {WORD_ZERO, $past(rd_data[0][derf_pkg::RD_DM_EVEN][DW-1 -: WW])})
      else $error("32-bit read not left-justified");
endmodule

// ---- sim/derf_cu_model.sv ----
/*
 Behavioural compute units of both elements, seen from the register file.
 Assumes operands arrive combinationally and results are taken same cycle.
*/
`timescale 1ns/10ps
module derf_cu_model (
   input  wire logic [1:0][39:0] op_a_i,
   input  wire logic [1:0][39:0] op_b_i,
   output logic      [1:0][39:0] alu_o,
   output logic      [1:0][39:0] mult_o
);
   // One instruction, each element on its own operands
   for (genvar e = 0; e < 2; e++) begin : g_pe
      assign alu_o[e]  = op_a_i[e] + op_b_i[e];
      assign mult_o[e] = op_a_i[e] ^ op_b_i[e]; // Stand-in, only a tag
   end
endmodule

// ---- sim/tb_top.sv ----
/*
 Bench for the dual element register file, one task per scenario.
 Assumes inputs change on falling edges and writes show after the edge.
*/
`timescale 1ns/10ps
module tb_top;
   logic clk_i, rst_i, alt_set_i, multi_data_mode_i, alu_wr_i, mult_wr_i;
   logic shift_wr_i, dm_en_i, dm_wr_i, dm_second_i, pm_en_i, pm_wr_i;
   logic pm_second_i, px_ld_dm_i, px_ld_pm_i, ur_en_i, ur_refused_o;
   logic mr_wr_i, mr_swap_i;
   logic [3:0] op_a_idx_i, op_b_idx_i, alu_idx_i, mult_idx_i, shift_idx_i;
   logic [3:0] dm_idx_i, pm_idx_i, ur_src_idx_i, ur_dst_idx_i;
   logic [1:0][39:0] op_a_o, op_b_o, alu_res_i, mult_res_i, shift_res_i;
   logic [1:0][63:0] dm_wdata_i, dm_rdata_o, pm_wdata_i, pm_rdata_o;
   logic [1:0][79:0] mr_res_i, mr_fore_o;
   logic [63:0] px_o;
   logic [23:0] pc_i, fetch_addr_i, decode_addr_i;
   derf_pkg::derf_xfer_t dm_xfer_i, pm_xfer_i;
   derf_pkg::derf_ureg_t ur_src_i, ur_dst_i;
   int error_cnt, check_count;
   localparam logic [63:0] W0 = 64'h1122334455667788;
   localparam logic [63:0] W1 = 64'h99aabbccddeeff00;
   localparam logic [39:0] A4 = {W0[31:0], 8'h00};
   localparam logic [39:0] B4 = {W1[31:0], 8'h00};

   derf_top uut (.*);
   derf_cu_model cu (.op_a_i(op_a_o), .op_b_i(op_b_o), .alu_o(alu_res_i),
      .mult_o(mult_res_i));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic chk(input string n, input logic [159:0] s, e);
      check_count++;
      if (s !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cyc;
      @(posedge clk_i);
      @(negedge clk_i);
   endtask
   // Operand port doubles as the register peek path
   task automatic see(input string n, input [3:0] i, input [79:0] e);
      op_a_idx_i = i;
      #1 chk(n, op_a_o, e);
   endtask
   task automatic wrap_up;
      $display("Checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Long-word pair load on one bus, read back whole on the other
   task automatic t_lw;
      {dm_en_i, dm_wr_i, dm_second_i, dm_idx_i} = {3'b111, 4'h5};
      dm_xfer_i = derf_pkg::XF_LW;
      dm_wdata_i = {W1, W0};
      cyc;
      dm_en_i = 1'b0;
      see("pair even", 4'h4, {B4, A4});
      see("pair odd", 4'h5, {W1[63:32], 8'h0, W0[63:32], 8'h0});
      {pm_en_i, pm_wr_i, pm_second_i, pm_idx_i} = {3'b101, 4'h4};
      pm_xfer_i = derf_pkg::XF_LW;
      cyc;
      pm_en_i = 1'b0;
      chk("lw read", pm_rdata_o, {W1, W0});
      $display("lw done");
   endtask
   // Both buses in one cycle, 32-bit and 40-bit formats
   task automatic t_dual;
      {dm_en_i, dm_second_i, dm_idx_i} = {2'b10, 4'h2};
      dm_xfer_i = derf_pkg::XF_32;
      {pm_en_i, pm_wr_i, pm_second_i, pm_idx_i} = {3'b111, 4'h3};
      pm_xfer_i = derf_pkg::XF_40;
      {dm_wr_i, pm_wdata_i} = {1'b1, W0, W1};
      cyc;
      see("w32", 4'h2, {40'h0, A4});
      see("w40", 4'h3, {W0[63:24], W1[63:24]});
      {dm_wr_i, dm_second_i, dm_idx_i, pm_en_i} = {2'b01, 4'h3, 1'b0};
      cyc;
      dm_en_i = 1'b0;
      chk("r32", dm_rdata_o, {32'h0, W0[63:32], 32'h0, W1[63:32]});
      $display("dual done");
   endtask
   // Bus load beats the ALU; single-data mode keeps the second file
   task automatic t_prec;
      {op_b_idx_i, op_a_idx_i, alu_idx_i, dm_idx_i} = {4'h4, 4'h4, 8'h66};
      // Multiplier and shifter aim at the same register and must lose
      {mult_wr_i, shift_wr_i, mult_idx_i, shift_idx_i} = {2'b11, 8'h66};
      {multi_data_mode_i, alu_wr_i, dm_en_i, dm_wr_i} = 4'hf;
      {dm_second_i, dm_wdata_i} = {1'b0, W1, W0};
      dm_xfer_i = derf_pkg::XF_40;
      cyc;
      {dm_en_i, mult_wr_i, shift_wr_i} = 3'b000;
      see("prio", 4'h6, {40'(B4 + B4), W0[63:24]});
      {multi_data_mode_i, alu_idx_i, op_a_idx_i} = {1'b0, 8'h74};
      cyc;
      alu_wr_i = 1'b0;
      see("single_data_mode", 4'h7, {40'h0, 40'(A4 + A4)});
      $display("prec done");
   endtask
   // Foreground result set, write and swap with background
   task automatic t_mr;
      {mr_wr_i, mr_res_i} = {1'b1, 80'h2, 80'h1};
      cyc;
      {mr_wr_i, mr_swap_i} = 2'b01;
      chk("mr wr", mr_fore_o, {80'h0, 80'h1});
      cyc;
      chk("mr swap", mr_fore_o, 160'h0);
      cyc;
      mr_swap_i = 1'b0;
      chk("mr back", mr_fore_o, {80'h0, 80'h1});
      $display("mr done");
   endtask
   // Read-only sequencer addresses refuse moves
   task automatic t_ref;
      ur_src_i = derf_pkg::UR_FIRST;
      ur_src_idx_i = 4'h4;
      for (int d = 5; d < 8; d++) begin
         ur_en_i = 1'b1;
         ur_dst_i = derf_pkg::derf_ureg_t'(d);
         cyc;
         ur_en_i = 1'b0;
         chk("refuse", ur_refused_o, 1'b1);
         cyc;
         chk("refuse end", ur_refused_o, 1'b0);
      end
      // Program counter still reads out as a left-justified word
      pc_i = 24'habcdef;
      ur_src_i = derf_pkg::UR_PC;
      ur_dst_i = derf_pkg::UR_FIRST;
      {ur_en_i, ur_dst_idx_i} = {1'b1, 4'hb};
      cyc;
      ur_en_i = 1'b0;
      see("pc read", 4'hb, {40'h0, 40'h00abcdef00});
      $display("ref done");
   endtask
   // Exchange register load, halves and combined moves to data
   task automatic t_px;
      {px_ld_dm_i, dm_wdata_i} = {1'b1, 64'h0, W1};
      cyc;
      {px_ld_dm_i, ur_en_i, ur_dst_idx_i} = {2'b01, 4'h9};
      ur_src_i = derf_pkg::UR_PX;
      ur_dst_i = derf_pkg::UR_FIRST;
      chk("px", px_o, W1);
      cyc;
      ur_src_i = derf_pkg::UR_PX_HI;
      ur_dst_idx_i = 4'ha;
      see("px comb", 4'h9, {40'h0, W1[63:24]});
      cyc;
      // Register back into the low half only, then combined self move
      ur_src_i = derf_pkg::UR_FIRST;
      ur_src_idx_i = 4'h9;
      ur_dst_i = derf_pkg::UR_PX_LOW;
      see("px half", 4'ha, {40'h0, W1[63:32], 8'h0});
      cyc;
      ur_src_i = derf_pkg::UR_PX;
      ur_dst_i = derf_pkg::UR_PX;
      chk("px low", px_o, {W1[63:32], W1[63:32]});
      cyc;
      ur_en_i = 1'b0;
      chk("px self", px_o, {W1[63:32], W1[63:56], 24'h0});
      $display("px done");
   endtask
   // Set switch with write in the switching cycle
   task automatic t_alt;
      {alt_set_i, dm_en_i, dm_wr_i, dm_idx_i} = {3'b111, 4'h4};
      dm_xfer_i = derf_pkg::XF_40;
      dm_wdata_i = {W0, W1};
      // Before the edge the old set still answers
      see("old set", 4'h4, {B4, A4});
      cyc;
      dm_en_i = 1'b0;
      see("alt set", 4'h4, 80'h0);
      cyc;
      see("alt stays", 4'h4, 80'h0);
      alt_set_i = 1'b0;
      cyc;
      cyc;
      see("kept", 4'h4, {B4, W1[63:24]});
      $display("alt done");
   endtask

   initial begin
      {alt_set_i, multi_data_mode_i, alu_wr_i, mult_wr_i, shift_wr_i} = '0;
      {dm_en_i, dm_wr_i, dm_second_i, pm_en_i, pm_wr_i, pm_second_i} = '0;
      {px_ld_dm_i, px_ld_pm_i, ur_en_i, mr_wr_i, mr_swap_i} = '0;
      {op_a_idx_i, op_b_idx_i, alu_idx_i, mult_idx_i, shift_idx_i} = '0;
      {dm_idx_i, pm_idx_i, ur_src_idx_i, ur_dst_idx_i, shift_res_i} = '0;
      {dm_wdata_i, pm_wdata_i, mr_res_i} = '0;
      {pc_i, fetch_addr_i, decode_addr_i} = '0;
      dm_xfer_i = derf_pkg::XF_32;
      pm_xfer_i = derf_pkg::XF_32;
      ur_src_i = derf_pkg::UR_FIRST;
      ur_dst_i = derf_pkg::UR_FIRST;
      {error_cnt, check_count, rst_i} = {32'h0, 32'h0, 1'b1};
      repeat (5) @(negedge clk_i);
      rst_i = 1'b0;
      t_lw;
      t_dual;
      t_prec;
      t_mr;
      t_ref;
      t_px;
      t_alt;
      wrap_up;
   end
   // Scenarios need well under 100 cycles
   initial begin
      #5000;
      error_cnt++;
      wrap_up;
   end
endmodule
